// ==== verif/spi_host_model.sv ====
// Host serial controller model that clocks frames into the converter
`timescale 1ns/10ps
module spi_host_model (
    // Clock
    input wire logic i_mclk,
    // Serial link
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b1;
    end

    task automatic wait_mclk(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : wait_mclk

    task automatic frame(input logic [15:0] word, input int bits, input int half,
                         output logic [15:0] rdata);
        rdata = 16'h0000;
        o_cs_n = 1'b0;
        for (int i = 0; i < bits; i++) begin
            o_sdi = word[15 - i];
            wait_mclk(half);
            o_sclk = 1'b1;
            rdata = {rdata[14:0], i_sdo};
            wait_mclk(half);
            o_sclk = 1'b0;
        end
        // Released data line must not look held
        o_sdi = ~o_sdi;
        o_cs_n = 1'b1;
        wait_mclk(16);
    endtask : frame
endmodule : spi_host_model

// ==== verif/tb_adc_reg_access.sv ====
// Self-checking bench for the serial register access block
`timescale 1ns/10ps
module tb_adc_reg_access;
    import adc_regs_pkg::*;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic sclk, cs_n, sdi, sdo_a, sdo_b, avg, res, crc_r, pd, alert;
    logic [2:0] oversample_ratio;
    logic [1:0] lane;
    logic [11:0] lo, hi;
    logic [11:0] flags = 12'h000;
    logic ce = 1'b1;
    logic [15:0] res_a = 16'hc3a5;
    logic [15:0] res_b = 16'h1234;
    logic [15:0] res_c = 16'h5678;
    logic [15:0] res_d = 16'h9abc;
    logic [15:0] r;
    int fails = 0;
    int checks_done = 0;
    logic [2:0] bad [4] = '{3'h0, 3'h3, 3'h6, 3'h7};

    adc_reg_access dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdi(sdi), .o_primary_result_output(sdo_a),
        .o_second_result_output(sdo_b), .i_result_a(res_a), .i_result_b(res_b),
        .i_result_c(res_c), .i_result_d(res_d), .i_limit_flags(flags),
        .o_averaging_style(avg), .o_oversample_ratio(oversample_ratio), .o_resolution_boost(res),
        .o_crc_read_en(crc_r), .o_power_down_select(pd), .o_output_lane_select(lane),
        .o_alert_en(alert), .o_lower_limit(lo), .o_upper_limit(hi));

    spi_host_model host (.i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
        .i_sdo(sdo_a));

    always #12.5 i_mclk = ~i_mclk;

    task automatic test_done;
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] sel, input logic [11:0] data);
        host.frame({1'b1, sel, data}, 16, 8, r);
    endtask : wr

    // Request, then a no-op frame carries the readback
    task automatic rd(input logic [2:0] sel, input logic [11:0] exp);
        host.frame({1'b0, sel, 12'h000}, 16, 8, r);
        host.frame(16'h0000, 16, 8, r);
        chk(r, {1'b0, sel, exp});
    endtask : rd

    function automatic logic [15:0] cfg_vec();
        return {8'h00, avg, oversample_ratio, res, pd, alert, crc_r};
    endfunction : cfg_vec

    initial begin
        repeat (100000) @(posedge i_mclk);
        fails++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge i_mclk);
        #1 i_nrst = 1'b1;
        host.wait_mclk(6);
        rd(SEL_DEV_CFG, DEV_CFG_RST);
        rd(SEL_OUT_CFG, OUT_CFG_RST);
        rd(SEL_LIMIT_FLAGS, 12'h000);
        rd(SEL_LOWER, LOWER_RST);
        rd(SEL_UPPER, UPPER_RST);
        // Pending readback, then a no-op read gives results
        for (int i = 0; i < 4; i++) begin
            if (bad[i] == SEL_LIMIT_FLAGS) continue;
            host.frame({1'b0, SEL_UPPER, 12'h000}, 16, 8, r);
            host.frame({1'b0, bad[i], 12'hfff}, 16, 8, r);
            chk(r, {1'b0, SEL_UPPER, UPPER_RST});
            host.frame(16'h0000, 16, 8, r);
            chk(r, 16'hc3a5);
        end
        wr(SEL_LOWER, 12'h123);
        wr(SEL_UPPER, 12'hfed);
        for (int i = 0; i < 4; i++) begin
            wr(bad[i], 12'hfff);
        end
        chk({4'h0, lo}, 16'h0123);
        chk({4'h0, hi}, 16'h0fed);
        rd(SEL_LIMIT_FLAGS, 12'h000);
        rd(SEL_DEV_CFG, 12'h000);
        wr(SEL_DEV_CFG, 12'hecd);
        chk(cfg_vec(), {8'h00, 1'b1, 3'h3, 1'b1, 1'b1, 1'b0, 1'b0});
        rd(SEL_DEV_CFG, 12'h2cd);
        wr(SEL_OUT_CFG, 12'h100);
        flags = 12'h040;
        host.wait_mclk(4);
        chk({14'h0, alert, sdo_b}, 16'h0003);
        rd(SEL_LIMIT_FLAGS, 12'h040);
        flags = 12'h000;
        host.wait_mclk(4);
        chk({15'h0, sdo_b}, 16'h0000);
        wr(SEL_OUT_CFG, 12'h200);
        chk({14'h0, lane}, 16'h0002);
        // Rolling mode with 4x, crc read on
        wr(SEL_DEV_CFG, 12'h294);
        chk(cfg_vec(), {8'h00, 1'b1, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1});
        for (int c = 0; c < 8; c++) begin
            wr(SEL_DEV_CFG, {3'h0, c[2:0], 6'h04});
            chk({13'h0, oversample_ratio}, (c <= 5) ? 16'(c) : 16'h0000);
            if (c <= 5) begin
                chk({15'h0, res}, {15'h0, c != 0});
            end
        end
        // Checksum enable without a checksum drops the frame
        wr(SEL_DEV_CFG, 12'h021);
        chk({15'h0, pd}, 16'h0000);
        rd(SEL_DEV_CFG, 12'h1c4);
        // Short frame dropped, slow host accepted
        host.frame({1'b1, SEL_LOWER, 12'h0aa}, 15, 8, r);
        chk({4'h0, lo}, 16'h0123);
        host.frame({1'b1, SEL_UPPER, 12'h456}, 16, 12, r);
        chk({4'h0, hi}, 16'h0456);
        test_done();
    end
endmodule : tb_adc_reg_access

// ==== verilog/adc_reg_access.sv ====
// Serial register access and configuration store of the quad converter
`timescale 1ns/10ps
module adc_reg_access
    import adc_regs_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Serial link pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic o_primary_result_output,
    output logic o_second_result_output,
    // Conversion results and limit flags
    input wire logic [15:0] i_result_a,
    input wire logic [15:0] i_result_b,
    input wire logic [15:0] i_result_c,
    input wire logic [15:0] i_result_d,
    input wire logic [11:0] i_limit_flags,
    // Configuration outputs
    output logic o_averaging_style,
    output logic [2:0] o_oversample_ratio,
    output logic o_resolution_boost,
    output logic o_crc_read_en,
    output logic o_power_down_select,
    output logic [1:0] o_output_lane_select,
    output logic o_alert_en,
    output logic [11:0] o_lower_limit,
    output logic [11:0] o_upper_limit
);
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [23:0] in_sr;
        logic [4:0] cnt;
        logic [63:0] out_a;
        logic [15:0] out_b;
        logic rd_pend;
        logic [2:0] rd_addr;
        logic [11:0] dev_cfg;
        logic [11:0] out_cfg;
        logic [11:0] lower;
        logic [11:0] upper;
        logic sdo_a;
        logic sdo_b;
        logic avg;
        logic [2:0] oversample_ratio;
        logic res;
        logic crc_r;
        logic pd;
        logic [1:0] lane;
        logic alert_en;
    } state_s;

    state_s q;
    state_s d;
    logic [2:0] pins;
    logic s_sclk;
    logic s_cs_n;
    logic s_sdi;

    pin_sync #(
        .W(3),
        .RST_VAL(3'h3)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_async({i_sclk, i_cs_n, i_sdi}),
        .o_level(pins)
    );
    assign s_sclk = pins[2];
    assign s_cs_n = pins[1];
    assign s_sdi = pins[0];

    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc8

    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic [15:0] word;
    logic len_ok;
    logic crc_ok;
    logic is_wr;
    logic [2:0] sel;
    logic [11:0] dat;
    logic wr_legal;
    logic wr_apply;
    logic rd_req;
    logic [15:0] rd_word;

    always_comb begin
        d = q;
        d.sclk = s_sclk;
        d.cs_n = s_cs_n;
        cs_fall = q.cs_n & ~s_cs_n;
        cs_rise = ~q.cs_n & s_cs_n;
        sck_rise = ~q.sclk & s_sclk & ~s_cs_n;
        sck_fall = q.sclk & ~s_sclk & ~s_cs_n;
        len_ok = (q.cnt == 5'(FRAME_BITS)) || (q.cnt == 5'(CRC_FRAME_BITS));
        word = (q.cnt == 5'(CRC_FRAME_BITS)) ? q.in_sr[23:8] : q.in_sr[15:0];
        crc_ok = (q.cnt == 5'(CRC_FRAME_BITS)) && (q.in_sr[7:0] == crc8(word));
        is_wr = word[WR_BIT];
        sel = word[SEL_HI:SEL_LO];
        dat = word[11:0];
        if (q.dev_cfg[CRC_W_BIT]) begin
            wr_legal = crc_ok;
        end else begin
            wr_legal = crc_ok || ((q.cnt == 5'(FRAME_BITS))
                && !((sel == SEL_DEV_CFG) && dat[CRC_W_BIT]));
        end
        wr_apply = cs_rise && is_wr && wr_legal;
        rd_req = cs_rise && !is_wr && len_ok;
        case (q.rd_addr)
            SEL_DEV_CFG: rd_word = {1'b0, SEL_DEV_CFG, q.dev_cfg};
            SEL_OUT_CFG: rd_word = {1'b0, SEL_OUT_CFG, q.out_cfg};
            SEL_LIMIT_FLAGS: rd_word = {1'b0, SEL_LIMIT_FLAGS, i_limit_flags};
            SEL_LOWER: rd_word = {1'b0, SEL_LOWER, q.lower};
            SEL_UPPER: rd_word = {1'b0, SEL_UPPER, q.upper};
            default: rd_word = 16'h0000;
        endcase

        if (cs_fall) begin
            d.cnt = 5'h00;
            d.out_b = i_result_b;
            d.rd_pend = 1'b0;
            if (q.rd_pend) begin
                d.out_a = {rd_word, 48'h000000000000};
            end else begin
                d.out_a = {i_result_a, i_result_b, i_result_c, i_result_d};
            end
        end
        if (sck_rise) begin
            d.in_sr = {q.in_sr[22:0], s_sdi};
            if (q.cnt != 5'h1f) begin
                d.cnt = q.cnt + 5'h01;
            end
        end
        if (sck_fall) begin
            d.out_a = {q.out_a[62:0], 1'b0};
            d.out_b = {q.out_b[14:0], 1'b0};
        end

        // load data bits; other selects dropped
        if (wr_apply) begin
            case (sel)
                SEL_DEV_CFG: d.dev_cfg = dat & DEV_CFG_MASK;
                SEL_OUT_CFG: d.out_cfg = dat & OUT_CFG_MASK;
                SEL_LOWER: d.lower = dat;
                SEL_UPPER: d.upper = dat;
                default: d.dev_cfg = q.dev_cfg;
            endcase
        end
        // no-op reads fall back to results
        if (rd_req) begin
            if ((sel >= SEL_DEV_CFG) && (sel <= SEL_UPPER)) begin
                d.rd_pend = 1'b1;
                d.rd_addr = sel;
            end else begin
                d.rd_pend = 1'b0;
            end
        end

        d.avg = d.dev_cfg[AVG_STYLE_BIT];
        if (d.dev_cfg[OSR_HI:OSR_LO] <= OSR_MAX_CODE) begin
            d.oversample_ratio = d.dev_cfg[OSR_HI:OSR_LO];
        end else begin
            d.oversample_ratio = 3'h0;
        end
        d.res = d.dev_cfg[RES_BIT] && (d.oversample_ratio != 3'h0);
        d.crc_r = d.dev_cfg[CRC_R_BIT];
        d.pd = d.dev_cfg[PD_BIT];
        d.lane = d.out_cfg[LANE_HI:LANE_LO];
        // flag pin only on one-wire lane
        d.alert_en = d.dev_cfg[ALERT_EN_BIT] && (d.lane == LANE_ONE_WIRE);
        d.sdo_a = d.out_a[63];
        d.sdo_b = d.alert_en ? (|i_limit_flags) : d.out_b[15];
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
            q.sclk <= 1'b0;
            q.cs_n <= 1'b1;
            q.dev_cfg <= DEV_CFG_RST;
            q.out_cfg <= OUT_CFG_RST;
            q.lower <= LOWER_RST;
            q.upper <= UPPER_RST;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_primary_result_output = q.sdo_a;
    assign o_second_result_output = q.sdo_b;
    assign o_averaging_style = q.avg;
    assign o_oversample_ratio = q.oversample_ratio;
    assign o_resolution_boost = q.res;
    assign o_crc_read_en = q.crc_r;
    assign o_power_down_select = q.pd;
    assign o_output_lane_select = q.lane;
    assign o_alert_en = q.alert_en;
    assign o_lower_limit = q.lower;
    assign o_upper_limit = q.upper;

    // Checks; a frozen enable holds state so guard each next-cycle trigger with it
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    a_ro_write_dropped: assert property (
        i_ce && cs_rise && is_wr && (sel == SEL_LIMIT_FLAGS) |=>
            $stable(q.dev_cfg) && $stable(q.out_cfg) && $stable(q.lower) && $stable(q.upper))
        else $error("write to read-only register changed state");
    a_nop_write_dropped: assert property (
        i_ce && cs_rise && is_wr && ((sel == SEL_NOP0) || (sel > SEL_UPPER)) |=>
            $stable(q.dev_cfg) && $stable(q.out_cfg) && $stable(q.lower) && $stable(q.upper))
        else $error("write to no-op slot changed state");
    a_nop_read_results: assert property (
        i_ce && rd_req && ((sel == SEL_NOP0) || (sel > SEL_UPPER)) |=> !q.rd_pend)
        else $error("no-op read left a readback pending");
    a_frame_length: assert property (
        wr_apply |-> (q.cnt == 5'd16) || (q.cnt == 5'd24))
        else $error("write applied from a frame of wrong length");
    a_header_bit: assert property (
        i_ce && wr_apply && (q.cnt == 5'd16) |-> q.in_sr[15])
        else $error("write applied without select bit set");
    a_write_loads: assert property (
        i_ce && wr_apply && (sel == SEL_LOWER) |=> q.lower == $past(dat))
        else $error("lower limit not loaded");
    a_read_pending: assert property (
        i_ce && rd_req && (sel == SEL_UPPER) |=> q.rd_pend && (q.rd_addr == SEL_UPPER))
        else $error("read request not scheduled");
    a_addr_in_word: assert property (
        i_ce && cs_fall && q.rd_pend |=> q.out_a[63:60] == {1'b0, $past(q.rd_addr)})
        else $error("readback word lacks its address");
    a_ratio_decode: assert property (
        q.oversample_ratio == ((q.dev_cfg[8:6] > 3'h5) ? 3'h0 : q.dev_cfg[8:6]))
        else $error("ratio decode wrong");
    a_crc_guard: assert property (
        i_ce && !$stable(q.dev_cfg[5]) |-> $past(crc_ok) && $past(wr_apply))
        else $error("checksum enable changed without valid checksum");
    a_boost_gated: assert property (
        q.res |-> q.dev_cfg[2] && (q.oversample_ratio != 3'h0))
        else $error("boost active without oversampling");
    a_flag_lane: assert property (
        q.alert_en |-> q.dev_cfg[3] && (q.lane == 2'h1))
        else $error("flag output on wrong lane");

    c_write_frame: cover property (wr_apply);
    c_readback: cover property (i_ce && cs_fall && q.rd_pend);
    c_crc_enable: cover property (wr_apply && crc_ok && (sel == SEL_DEV_CFG));
    c_nop_read: cover property (rd_req && (sel == SEL_NOP0));
endmodule : adc_reg_access

// ==== verilog/adc_regs_pkg.sv ====
// Constants for the serial register access block of the quad converter
// How it works
// - Writes to read-only registers and reads of write-only ones change nothing.
// - Writes to no-operation slots or the reserved register are ignored.
// - Reads of no-operation or reserved slots return conversion results next frame.
// - A register transfer is 16 serial clocks when the checksum is off.
// - First four bits: write/read select, then three register-select bits, MSB first.
// - Write to a valid writable register loads its writable data bits; only the limits take all twelve.
// - Read request puts the register on the primary output next access.
// - Read request to select 0, 6 or 7 yields conversion results next.
// - Bits 15 to 12 of each register word carry its own address.
// - Bit 9 of device configuration picks block or rolling averaging.
// - Ratio field bits 8 to 6: 000 disables, 001 gives 2x, all converters.
// - Checksum enable bit changes only with a valid checksum, else frame dropped.
// - Resolution boost adds two bits, ignored while ratio field is zero.
// - Threshold flag replaces second output only when lane select equals 01.
// - Power-down select bit 0: 0 normal operation, 1 shutdown.
package adc_regs_pkg;
    // Register selects
    localparam logic [2:0] SEL_NOP0 = 3'h0;
    localparam logic [2:0] SEL_DEV_CFG = 3'h1;
    localparam logic [2:0] SEL_OUT_CFG = 3'h2;
    localparam logic [2:0] SEL_LIMIT_FLAGS = 3'h3;
    localparam logic [2:0] SEL_LOWER = 3'h4;
    localparam logic [2:0] SEL_UPPER = 3'h5;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int CRC_FRAME_BITS = 24;
    localparam int WR_BIT = 15;
    localparam int SEL_HI = 14;
    localparam int SEL_LO = 12;
    // Device configuration fields
    localparam int AVG_STYLE_BIT = 9;
    localparam int OSR_HI = 8;
    localparam int OSR_LO = 6;
    localparam int CRC_W_BIT = 5;
    localparam int CRC_R_BIT = 4;
    localparam int ALERT_EN_BIT = 3;
    localparam int RES_BIT = 2;
    localparam int PD_BIT = 0;
    // Output configuration fields
    localparam int LANE_HI = 9;
    localparam int LANE_LO = 8;
    localparam logic [1:0] LANE_ONE_WIRE = 2'h1;
    // Writable masks and reset values
    localparam logic [11:0] DEV_CFG_MASK = 12'h3fd;
    localparam logic [11:0] OUT_CFG_MASK = 12'h300;
    localparam logic [11:0] DEV_CFG_RST = 12'h000;
    localparam logic [11:0] OUT_CFG_RST = 12'h000;
    localparam logic [11:0] LOWER_RST = 12'h800;
    localparam logic [11:0] UPPER_RST = 12'h7ff;
    // Ratio codes
    localparam logic [2:0] OSR_MAX_CODE = 3'h5;
    // Write checksum
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hff;
endpackage : adc_regs_pkg

// ==== verilog/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and control
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Pins
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d = q;
        d.ff1 = i_async;
        d.ff2 = q.ff1;
        d.ff3 = q.ff2;
        // Only move once the two later stages agree
        d.lvl = (~(q.ff2 ^ q.ff3) & q.ff3) | ((q.ff2 ^ q.ff3) & q.lvl);
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_level = q.lvl;
endmodule : pin_sync
